/* File: core/dft_pkg.sv */
// Summary of operation
// - three 8-bit target registers, 1 degree steps
// - targets at 0x33, 0x34, 0x35
// - targets reset to 0xA4, 100 degrees
// - below low limit sets low flag
// - above high limit sets high flag
// - fan turns on at fan-start temperature
// - dynamic mode moves fan-start toward target
// - each zone regulated against own target
// - too cool: raise fan-start temperature
// - too hot: lower fan-start temperature
// - above its critical limit, a zone drives its own fan at full duty
// - range code sets duty slope above fan-start
// - short cycle every n, long every 2n
// - long cycle lowers fan-start while above target
// - fan-start never raised above high limit
// - long-cycle raise only below low limit
package dft_pkg;
	localparam int NCH = 3;

	typedef logic [7:0] dft_temp_t;

	// per-channel settings handed to the channel loop
	typedef struct packed {
		logic [7:0] target;
		logic [7:0] low;
		logic [7:0] high;
		logic [7:0] crit;
		logic [3:0] hyst;
		logic [2:0] cycle_code;
		logic [2:0] range_code;
		logic [7:0] min_duty;
		logic       dyn_en;
	} dft_cfg_s;

	// per-channel register addresses, index 0 remote 1, 1 local, 2 remote 2
	localparam logic [NCH-1:0][7:0] ADDR_TARGET = {8'h35, 8'h34, 8'h33};
	localparam logic [NCH-1:0][7:0] ADDR_LOW    = {8'h52, 8'h50, 8'h4E};
	localparam logic [NCH-1:0][7:0] ADDR_HIGH   = {8'h53, 8'h51, 8'h4F};
	localparam logic [NCH-1:0][7:0] ADDR_CRIT   = {8'h6C, 8'h6B, 8'h6A};
	localparam logic [NCH-1:0][7:0] ADDR_FSTART = {8'h7E, 8'h7D, 8'h7C};
	localparam logic [NCH-1:0][7:0] ADDR_RANGE  = {8'h82, 8'h81, 8'h80};
	localparam logic [7:0] ADDR_CAL1     = 8'h36;
	localparam logic [7:0] ADDR_CAL2     = 8'h37;
	localparam logic [7:0] ADDR_HYST12   = 8'h6D;
	localparam logic [7:0] ADDR_HYST3    = 8'h6E;
	localparam logic [7:0] ADDR_STATUS   = 8'h7A;
	localparam logic [7:0] ADDR_DYN_EN   = 8'h7B;
	localparam logic [7:0] ADDR_MIN_DUTY = 8'h83;

	// reset values
	localparam logic [7:0] RST_TARGET   = 8'hA4;
	localparam logic [7:0] RST_LOW      = 8'h01;
	localparam logic [7:0] RST_HIGH     = 8'h7F;
	localparam logic [7:0] RST_CRIT     = 8'hA4;
	localparam logic [7:0] RST_FSTART   = 8'h90;
	localparam logic [2:0] RST_RANGE    = 3'h2;
	localparam logic [7:0] RST_HYST12   = 8'h44;
	localparam logic [7:0] RST_HYST3    = 8'h40;
	localparam logic [7:0] RST_CAL2     = 8'h00;
	localparam logic [7:0] RST_MIN_DUTY = 8'h80;
	localparam logic [7:0] FULL_DUTY    = 8'hFF;

	// field positions
	localparam int HYST_HI_LSB   = 4;
	localparam int HYST_LO_LSB   = 0;
	localparam int CYC_R1_LSB    = 0;
	localparam int CYC_LOC_LSB   = 3;
	localparam int CYC_R2_LSB    = 6;
	localparam int STAT_LOW_LSB  = 0;
	localparam int STAT_HIGH_LSB = 3;

	// short cycle of 8 monitoring cycles at code 000, doubling per code step
	localparam logic [11:0] SHORT_BASE = 12'h008;
	localparam int          CNT_W      = 12;
endpackage

/* File: core/dft_chan.sv */
`timescale 1ns/100ps
module dft_chan (
	input  wire logic             clk_sys,
	input  wire logic             rst,
	input  wire logic             tick,
	input  wire dft_pkg::dft_cfg_s cfg,
	input  wire dft_pkg::dft_temp_t temp,
	input  wire logic             host_wr,
	input  wire logic [7:0]       host_data,
	output logic [7:0]            fan_start,
	output logic [7:0]            duty,
	output logic                  fan_on,
	output logic                  low_evt,
	output logic                  high_evt
);
	import dft_pkg::*;

	logic [CNT_W-1:0] cnt;
	logic [7:0]       prev_temp;
	logic             crit_hold;

	// cycle boundaries: n = 8 << code, long = 2n; counter wraps on a multiple of both
	wire  [CNT_W-1:0] short_len = SHORT_BASE << cfg.cycle_code;
	wire  [CNT_W-1:0] cnt_nx    = cnt + 12'h001;
	wire              short_hit = (cnt_nx & (short_len - 12'h001)) == 12'h000;
	wire              long_hit  = (cnt_nx & ((short_len << 1) - 12'h001)) == 12'h000;

	// zone comparisons, each saturating subtraction floors at zero
	wire  [7:0] op_minus_h = (cfg.target > {4'h0, cfg.hyst}) ? cfg.target - {4'h0, cfg.hyst} : 8'h00;
	wire  [7:0] fs_minus_h = (fan_start > {4'h0, cfg.hyst}) ? fan_start - {4'h0, cfg.hyst} : 8'h00;
	wire  [7:0] cr_minus_h = (cfg.crit > {4'h0, cfg.hyst}) ? cfg.crit - {4'h0, cfg.hyst} : 8'h00;
	wire        above_band = temp > op_minus_h;
	wire        above_op   = temp > cfg.target;
	wire        below_low  = temp < cfg.low;
	wire        rising     = temp > prev_temp;

	// short cycle takes twice the rise since the last monitoring cycle, long adds one
	wire  [9:0] short_dec  = (short_hit && above_band && rising) ? {1'b0, temp - prev_temp, 1'b0} : 10'h000;
	wire  [9:0] long_dec   = (long_hit && above_op) ? 10'h001 : 10'h000;
	wire  [9:0] dec_total  = short_dec + long_dec;
	wire  [7:0] fs_lowered = ({2'b00, fan_start} > dec_total) ? fan_start - dec_total[7:0] : 8'h00;
	// raise only in the long cycle, only below low limit, capped by high limit
	wire        may_raise  = long_hit && !above_op && below_low && (fan_start < cfg.high);
	wire  [7:0] fs_adjust  = (dec_total != 10'h000) ? fs_lowered :
	                         may_raise ? fan_start + 8'h01 : fan_start;
	wire  [7:0] next_fstart = host_wr ? host_data :
	                          (tick && cfg.dyn_en) ? fs_adjust : fan_start;

	// duty curve: min duty at fan-start, slope set by range code, saturated at full
	wire  [15:0] over      = {8'h00, temp - fan_start} << cfg.range_code;
	wire  [15:0] ramp      = {8'h00, cfg.min_duty} + over;
	wire  [7:0]  curve     = (ramp > {8'h00, FULL_DUTY}) ? FULL_DUTY : ramp[7:0];
	wire         next_crit = crit_hold ? (temp >= cr_minus_h) : (temp > cfg.crit);
	wire         next_on   = fan_on ? (temp >= fs_minus_h) : (temp >= fan_start);
	wire  [7:0]  next_duty = next_crit ? FULL_DUTY :
	                         !next_on ? 8'h00 :
	                         (temp >= fan_start) ? curve : cfg.min_duty;

	// the host write wins over a loop adjustment landing in the same cycle
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			fan_start <= RST_FSTART;
		end else begin
			fan_start <= next_fstart;
		end
	end

	// all evaluation happens once per finished monitoring cycle
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cnt       <= '0;
			prev_temp <= 8'h00;
			crit_hold <= 1'b0;
			fan_on    <= 1'b0;
			duty      <= 8'h00;
			low_evt   <= 1'b0;
			high_evt  <= 1'b0;
		end else begin
			low_evt  <= tick && below_low;
			high_evt <= tick && (temp > cfg.high);
			if (tick) begin
				cnt       <= cnt_nx;
				prev_temp <= temp;
				crit_hold <= next_crit;
				fan_on    <= next_on;
				duty      <= next_duty;
			end
		end
	end
endmodule

/* File: core/dft_top.sv */
`timescale 1ns/100ps
module dft_top (
	input  wire logic                                     clk_sys,
	input  wire logic                                     rst,
	input  wire dft_pkg::dft_temp_t [dft_pkg::NCH-1:0]    temp_in,
	input  wire logic                                     mon_done,
	input  wire logic [7:0]                               reg_addr,
	input  wire logic [7:0]                               reg_wdata,
	input  wire logic                                     reg_wr,
	input  wire logic                                     reg_rd,
	output logic [7:0]                                    reg_rdata,
	output logic [dft_pkg::NCH-1:0][7:0]                  fan_duty,
	output logic [dft_pkg::NCH-1:0]                       fan_on,
	output logic [dft_pkg::NCH-1:0]                       low_flag,
	output logic [dft_pkg::NCH-1:0]                       high_flag
);
	import dft_pkg::*;

	logic [NCH-1:0][7:0] target;
	logic [NCH-1:0][7:0] low_temp_limit;
	logic [NCH-1:0][7:0] high_temp_limit;
	logic [NCH-1:0][7:0] critical_temp_limit;
	logic [NCH-1:0][2:0] range_code;
	logic [7:0]          minimum_duty;
	logic [7:0]          hyst12;
	logic [7:0]          hyst3;
	logic                cal1_bit;
	logic [7:0]          cal2;
	logic [NCH-1:0]      dyn_en;
	logic [NCH-1:0][7:0] fan_start_temp;
	logic [NCH-1:0]      low_evt;
	logic [NCH-1:0]      high_evt;
	logic [NCH-1:0][3:0] ch_hyst;
	logic [NCH-1:0][2:0] ch_code;
	dft_cfg_s [NCH-1:0]  ch_cfg;
	logic [NCH-1:0]      wr_target;
	logic [NCH-1:0]      wr_low;
	logic [NCH-1:0]      wr_high;
	logic [NCH-1:0]      wr_crit;
	logic [NCH-1:0]      wr_range;
	logic [NCH-1:0]      wr_fstart;

	// shared register decode
	wire wr_min   = reg_wr && (reg_addr == ADDR_MIN_DUTY);
	wire wr_h12   = reg_wr && (reg_addr == ADDR_HYST12);
	wire wr_h3    = reg_wr && (reg_addr == ADDR_HYST3);
	wire wr_cal1  = reg_wr && (reg_addr == ADDR_CAL1);
	wire wr_cal2  = reg_wr && (reg_addr == ADDR_CAL2);
	wire wr_dyn   = reg_wr && (reg_addr == ADDR_DYN_EN);
	wire rd_stat  = reg_rd && (reg_addr == ADDR_STATUS);

	// hysteresis and cycle-code fields split per channel
	assign ch_hyst[0] = hyst12[HYST_HI_LSB +: 4];
	assign ch_hyst[1] = hyst12[HYST_LO_LSB +: 4];
	assign ch_hyst[2] = hyst3[HYST_HI_LSB +: 4];
	assign ch_code[0] = cal2[CYC_R1_LSB +: 3];
	assign ch_code[1] = cal2[CYC_LOC_LSB +: 3];
	assign ch_code[2] = {cal1_bit, cal2[CYC_R2_LSB +: 2]};

	// per-channel registers and loops, each zone against its own target
	genvar gi;
	generate
		for (gi = 0; gi < NCH; gi++) begin : g_ch
			assign wr_target[gi] = reg_wr && (reg_addr == ADDR_TARGET[gi]);
			assign wr_low[gi]    = reg_wr && (reg_addr == ADDR_LOW[gi]);
			assign wr_high[gi]   = reg_wr && (reg_addr == ADDR_HIGH[gi]);
			assign wr_crit[gi]   = reg_wr && (reg_addr == ADDR_CRIT[gi]);
			assign wr_range[gi]  = reg_wr && (reg_addr == ADDR_RANGE[gi]);
			assign wr_fstart[gi] = reg_wr && (reg_addr == ADDR_FSTART[gi]);

			assign ch_cfg[gi] = '{target:     target[gi],
			                      low:        low_temp_limit[gi],
			                      high:       high_temp_limit[gi],
			                      crit:       critical_temp_limit[gi],
			                      hyst:       ch_hyst[gi],
			                      cycle_code: ch_code[gi],
			                      range_code: range_code[gi],
			                      min_duty:   minimum_duty,
			                      dyn_en:     dyn_en[gi]};

			// 8-bit target, one degree per step, 0xA4 after reset
			always_ff @(posedge clk_sys or posedge rst) begin
				if (rst) begin
					target[gi]              <= RST_TARGET;
					low_temp_limit[gi]      <= RST_LOW;
					high_temp_limit[gi]     <= RST_HIGH;
					critical_temp_limit[gi] <= RST_CRIT;
					range_code[gi]          <= RST_RANGE;
				end else begin
					if (wr_target[gi])
						target[gi] <= reg_wdata;
					if (wr_low[gi])
						low_temp_limit[gi] <= reg_wdata;
					if (wr_high[gi])
						high_temp_limit[gi] <= reg_wdata;
					if (wr_crit[gi])
						critical_temp_limit[gi] <= reg_wdata;
					if (wr_range[gi])
						range_code[gi] <= reg_wdata[2:0];
				end
			end

			dft_chan u_chan (
				.clk_sys   (clk_sys),
				.rst       (rst),
				.tick      (mon_done),
				.cfg       (ch_cfg[gi]),
				.temp      (temp_in[gi]),
				.host_wr   (wr_fstart[gi]),
				.host_data (reg_wdata),
				.fan_start (fan_start_temp[gi]),
				.duty      (fan_duty[gi]),
				.fan_on    (fan_on[gi]),
				.low_evt   (low_evt[gi]),
				.high_evt  (high_evt[gi])
			);
		end
	endgenerate

	// shared settings; the hardware does not police the programming order,
	// so enabling dynamic mode before the fan curve is set just adjusts defaults
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			minimum_duty <= RST_MIN_DUTY;
			hyst12       <= RST_HYST12;
			hyst3        <= RST_HYST3;
			cal1_bit     <= 1'b0;
			cal2         <= RST_CAL2;
			dyn_en       <= '0;
		end else begin
			if (wr_min)
				minimum_duty <= reg_wdata;
			if (wr_h12)
				hyst12 <= reg_wdata;
			if (wr_h3)
				hyst3 <= {reg_wdata[7:4], 4'h0};                                   // low nibble reserved
			if (wr_cal1)
				cal1_bit <= reg_wdata[0];
			if (wr_cal2)
				cal2 <= reg_wdata;
			if (wr_dyn)
				dyn_en <= reg_wdata[NCH-1:0];
		end
	end

	// sticky excursion flags: cleared by reading status, a new event wins
	wire [NCH-1:0] next_low  = (rd_stat ? '0 : low_flag) | low_evt;
	wire [NCH-1:0] next_high = (rd_stat ? '0 : high_flag) | high_evt;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			low_flag  <= '0;
			high_flag <= '0;
		end else begin
			low_flag  <= next_low;
			high_flag <= next_high;
		end
	end

	// read mux; unmapped addresses read zero
	function automatic logic [7:0] rd_mux(input logic [7:0] a);
		logic [7:0] v;
		v = 8'h00;
		for (int i = 0; i < NCH; i++) begin
			if (a == ADDR_TARGET[i])
				v = target[i];
			if (a == ADDR_LOW[i])
				v = low_temp_limit[i];
			if (a == ADDR_HIGH[i])
				v = high_temp_limit[i];
			if (a == ADDR_CRIT[i])
				v = critical_temp_limit[i];
			if (a == ADDR_RANGE[i])
				v = {5'h00, range_code[i]};
			if (a == ADDR_FSTART[i])
				v = fan_start_temp[i];
		end
		case (a)
			ADDR_MIN_DUTY: v = minimum_duty;
			ADDR_HYST12:   v = hyst12;
			ADDR_HYST3:    v = hyst3;
			ADDR_CAL1:     v = {7'h00, cal1_bit};
			ADDR_CAL2:     v = cal2;
			ADDR_DYN_EN:   v = {5'h00, dyn_en};
			ADDR_STATUS:   v = {2'b00, high_flag, low_flag};
			default:       v = v;
		endcase
		return v;
	endfunction

	// a process rather than an assign, so it also wakes when a register the mux reads changes
	logic [7:0] rd_value;

	always_comb begin
		rd_value = rd_mux(reg_addr);
	end

	// read data registered, held between reads
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= rd_value;
		end
	end
endmodule

/* File: tb/dft_chk.sv */
`timescale 1ns/100ps
module dft_chk (
	input wire logic                                  clk_sys,
	input wire logic                                  rst,
	input wire dft_pkg::dft_temp_t [dft_pkg::NCH-1:0] temp_in,
	input wire logic                                  mon_done,
	input wire logic [7:0]                            reg_addr,
	input wire logic [7:0]                            reg_wdata,
	input wire logic                                  reg_wr,
	input wire logic                                  reg_rd,
	input wire logic [7:0]                            reg_rdata,
	input wire logic [dft_pkg::NCH-1:0][7:0]          fan_duty,
	input wire logic [dft_pkg::NCH-1:0]               fan_on,
	input wire logic [dft_pkg::NCH-1:0]               low_flag,
	input wire logic [dft_pkg::NCH-1:0]               high_flag
);
	import dft_pkg::*;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	// status read strobe, the only thing allowed to clear a flag
	logic stat_rd;
	logic t0_wr;
	assign stat_rd = reg_rd && reg_addr == ADDR_STATUS;
	assign t0_wr   = reg_wr && reg_addr == ADDR_TARGET[0];

	rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data moved without a read");
	tgt_rdback_a: assert property (t0_wr ##1 !reg_wr ##1 (reg_rd && reg_addr == ADDR_TARGET[0] && !reg_wr)
		|=> reg_rdata == $past(reg_wdata, 3)) else $error("target read back differs from write");
	unmap_zero_a: assert property (reg_rd && reg_addr == 8'h00 |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	low_rise_a: assert property (|(low_flag & ~$past(low_flag)) |-> $past(mon_done, 2))
		else $error("low flag set without a monitoring cycle");
	high_rise_a: assert property (|(high_flag & ~$past(high_flag)) |-> $past(mon_done, 2))
		else $error("high flag set without a monitoring cycle");
	// a set from an event in flight wins over the clear, so exclude it
	stat_clear_a: assert property (stat_rd && !$past(mon_done) && !mon_done
		|=> low_flag == 3'b000 && high_flag == 3'b000) else $error("status read left flags set");
	flag_fall_a: assert property (|($past(low_flag | high_flag) & ~(low_flag | high_flag)) |-> $past(stat_rd))
		else $error("flag cleared without a status read");
	fan_time_a: assert property ($changed(fan_on) |-> $past(mon_done))
		else $error("fan on changed outside a monitoring cycle");
	duty_time_a: assert property ($changed(fan_duty) |-> $past(mon_done))
		else $error("duty changed outside a monitoring cycle");

	cover property (stat_rd);
	cover property ($rose(fan_on[0]));
	cover property (fan_duty[0] == FULL_DUTY);
endmodule

bind dft_top dft_chk i_chk (.clk_sys(clk_sys), .rst(rst), .temp_in(temp_in), .mon_done(mon_done),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.fan_duty(fan_duty), .fan_on(fan_on), .low_flag(low_flag), .high_flag(high_flag));

/* File: tb/tb.sv */
`timescale 1ns/100ps
module tb;
	import dft_pkg::*;
	logic                clk_sys   = 1'b0;
	logic                rst       = 1'b1;
	dft_temp_t [NCH-1:0] temp_in   = '0;
	logic                mon_done  = 1'b0;
	logic [7:0]          reg_addr  = 8'h00;
	logic [7:0]          reg_wdata = 8'h00;
	logic                reg_wr    = 1'b0;
	logic                reg_rd    = 1'b0;
	logic [7:0]          reg_rdata;
	logic [NCH-1:0][7:0] fan_duty;
	logic [NCH-1:0]      fan_on;
	logic [NCH-1:0]      low_flag;
	logic [NCH-1:0]      high_flag;
	int                  n_mismatch = 0;
	int                  checks     = 0;

	always #20 clk_sys = ~clk_sys;

	dft_top i_dut (.clk_sys(clk_sys), .rst(rst), .temp_in(temp_in), .mon_done(mon_done),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .fan_duty(fan_duty), .fan_on(fan_on), .low_flag(low_flag),
		.high_flag(high_flag));

	// inputs always move 1 ns after the edge, away from the sampling point
	task automatic cyc();
		@(posedge clk_sys);
		#1;
	endtask

	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// trailing idle cycle keeps two strobes from meeting in one time step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		cyc();
		reg_wr = 1'b0;
		cyc();
	endtask

	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		reg_addr = a;
		reg_rd = 1'b1;
		cyc();
		reg_rd = 1'b0;
		chk($sformatf("reg %h", a), reg_rdata, exp);
		cyc();
	endtask

	// flags land two edges after the pulse, so wait them out
	task automatic mon(input dft_temp_t t0, input dft_temp_t t1, input dft_temp_t t2);
		temp_in = {t2, t1, t0};
		mon_done = 1'b1;
		cyc();
		mon_done = 1'b0;
		cyc();
		cyc();
	endtask

	task automatic conclude();
		if (n_mismatch == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk_sys);
		n_mismatch++;
		conclude();
	end

	initial begin
		repeat (5) cyc();
		rst = 1'b0;
		for (int i = 0; i < NCH; i++) begin
			rdc(ADDR_TARGET[i], RST_TARGET);
			wr(ADDR_TARGET[i], 8'h50 + 8'(i));
			rdc(ADDR_TARGET[i], 8'h50 + 8'(i));
		end
		rdc(8'h00, 8'h00);
		// remote 1 under its low limit, local over its high limit
		mon(8'h00, 8'h80, 8'h40);
		chk("low_flag", {5'h00, low_flag}, 8'h01);
		chk("high_flag", {5'h00, high_flag}, 8'h02);
		rdc(ADDR_STATUS, 8'h11);
		chk("flags", {2'b00, high_flag, low_flag}, 8'h00);
		mon(8'h95, 8'h40, 8'h40);
		chk("fan_on", {5'h00, fan_on}, 8'h01);
		chk("duty", fan_duty[0], 8'h94);
		mon(8'hA5, 8'h40, 8'h40);
		chk("duty", fan_duty[0], FULL_DUTY);
		mon(8'h8D, 8'h40, 8'h40);
		chk("duty", fan_duty[0], RST_MIN_DUTY);
		mon(8'h8B, 8'h40, 8'h40);
		chk("fan_on", {5'h00, fan_on}, 8'h00);
		wr(ADDR_RANGE[0], 8'h00);
		mon(8'h95, 8'h40, 8'h40);
		chk("duty", fan_duty[0], 8'h85);
		// second reset restarts the cycle counter from a known phase
		rst = 1'b1;
		repeat (5) cyc();
		rst = 1'b0;
		wr(ADDR_TARGET[0], 8'h50);
		wr(ADDR_DYN_EN, 8'h01);
		repeat (15) mon(8'h60, 8'h40, 8'h40);
		rdc(ADDR_FSTART[0], RST_FSTART);
		mon(8'h60, 8'h40, 8'h40);
		rdc(ADDR_FSTART[0], 8'h8F);
		repeat (16) mon(8'h00, 8'h40, 8'h40);
		rdc(ADDR_FSTART[0], 8'h8F);
		wr(ADDR_HIGH[0], 8'hFF);
		repeat (16) mon(8'h00, 8'h40, 8'h40);
		rdc(ADDR_FSTART[0], 8'h90);
		rdc(ADDR_FSTART[1], RST_FSTART);
		// short cycle: a rise of 2 above the band takes 4 off fan-start
		repeat (7) mon(8'h4D, 8'h40, 8'h40);
		mon(8'h4F, 8'h40, 8'h40);
		rdc(ADDR_FSTART[0], 8'h8C);
		// a cut far larger than fan-start floors at zero
		wr(ADDR_FSTART[0], 8'h01);
		repeat (7) mon(8'h4F, 8'h40, 8'h40);
		mon(8'h60, 8'h40, 8'h40);
		rdc(ADDR_FSTART[0], 8'h00);
		// code 1 doubles both cycles, so tick 80 is no long cycle
		wr(ADDR_CAL2, 8'h01);
		wr(ADDR_FSTART[0], 8'h90);
		repeat (16) mon(8'h60, 8'h40, 8'h40);
		rdc(ADDR_FSTART[0], 8'h90);
		repeat (16) mon(8'h60, 8'h40, 8'h40);
		rdc(ADDR_FSTART[0], 8'h8F);
		conclude();
	end
endmodule
